// *** dv/adc_serial_port_framed_tb_top.sv ***
/*
 Bench: host end and converter end joined by one link, driven from both user sides.
 Assumes both ends share one clock; no fault-injecting host is attached.
*/
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin errors++; \
  $display("FAIL t=%0t got %h exp %h", $time, (a), (b)); end end
module adc_serial_port_framed_tb_top;
  logic        clock;
  logic        srst;
  logic        clk_en;
  logic        cmd_valid;
  logic        cmd_ready;
  logic        cmd_write;
  logic        cmd_select;
  logic        cmd_short;
  logic        cmd_wait_ready;
  logic [23:0] cmd_word;
  logic        rsp_valid;
  logic [23:0] rsp_word;
  logic        result_valid;
  logic [23:0] result_word;
  logic        out_word_short;
  logic        cal_read_sel;
  logic [23:0] cal_rd_word;
  logic [23:0] ctrl_word;
  logic        cal_wr_valid;
  logic [23:0] cal_wr_word;
  logic        result_lost;
  logic [23:0] rd_word;
  logic [23:0] cal_got;
  int          cal_cnt;
  int          lost_cnt;
  int          errors;
  int          cmp_count;

  asp_link_if asp_link_if_i ();

  asp_host_end asp_host_end_i (
    .clock(clock), .srst(srst), .clk_en(clk_en), .link(asp_link_if_i),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_write(cmd_write),
    .cmd_select(cmd_select), .cmd_short(cmd_short), .cmd_wait_ready(cmd_wait_ready),
    .cmd_word(cmd_word), .rsp_valid(rsp_valid), .rsp_word(rsp_word));

  asp_dev_end asp_dev_end_i (
    .clock(clock), .srst(srst), .clk_en(clk_en), .link(asp_link_if_i),
    .result_valid(result_valid), .result_word(result_word),
    .out_word_short(out_word_short), .cal_read_sel(cal_read_sel),
    .cal_rd_word(cal_rd_word), .ctrl_word(ctrl_word), .cal_wr_valid(cal_wr_valid),
    .cal_wr_word(cal_wr_word), .result_lost(result_lost));

  asp_link_properties asp_link_properties_i (
    .clock(clock), .srst(srst), .mode(asp_link_if_i.mode), .sclk(asp_link_if_i.sclk),
    .sclk_dev_o(asp_link_if_i.sclk_dev_o), .sclk_dev_oe_n(asp_link_if_i.sclk_dev_oe_n),
    .serial_data_io_dev_oe_n(asp_link_if_i.serial_data_io_dev_oe_n),
    .read_frame_sync_n(asp_link_if_i.read_frame_sync_n),
    .write_frame_sync_n(asp_link_if_i.write_frame_sync_n),
    .register_select(asp_link_if_i.register_select),
    .result_ready_n(asp_link_if_i.result_ready_n));

  always #2.5 clock = ~clock;

  // Pulses counted mid-cycle, clear of the edge that launches them
  always @(negedge clock) begin
    if (cal_wr_valid === 1'b1) begin
      cal_cnt++;
      cal_got = cal_wr_word;
    end
    if (result_lost === 1'b1) begin
      lost_cnt++;
    end
  end

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Outputs are read at the falling edge, where registered values have settled
  task automatic run_cmd(input logic wr, input logic sel, input logic shrt,
                         input logic wt, input logic [23:0] w);
    int n;
    n = 0;
    @(posedge clock);
    cmd_valid <= 1'b1;
    {cmd_write, cmd_select, cmd_short, cmd_wait_ready, cmd_word} <= {wr, sel, shrt, wt, w};
    do begin
      @(negedge clock);
      n++;
    end while (cmd_ready !== 1'b1 && n < 20000);
    @(posedge clock);
    cmd_valid <= 1'b0;
    do begin
      @(negedge clock);
      n++;
    end while ((wr ? cmd_ready !== 1'b1 : rsp_valid !== 1'b1) && n < 20000);
    rd_word = rsp_word;
    if (n >= 20000) begin
      errors++;
    end
  endtask

  task automatic push(input logic [23:0] w);
    @(posedge clock);
    result_valid <= 1'b1;
    result_word  <= w;
    @(posedge clock);
    result_valid <= 1'b0;
  endtask

  initial begin
    #200000;
    errors++;
    finish_test();
  end

  initial begin
    clock = 1'b0;
    srst = 1'b1;
    clk_en = 1'b1;
    cmd_valid = 1'b0;
    {cmd_write, cmd_select, cmd_short, cmd_wait_ready, cmd_word} = '0;
    result_valid = 1'b0;
    result_word = 24'h000000;
    out_word_short = 1'b0;
    cal_read_sel = 1'b0;
    cal_rd_word = 24'h13579b;
    asp_link_if_i.mode = 1'b0;
    cal_cnt = 0;
    lost_cnt = 0;
    errors = 0;
    cmp_count = 0;
    repeat (2) @(posedge clock);
    srst <= 1'b0;
    // External clock: control then calibration writes, control read back
    run_cmd(1'b1, 1'b0, 1'b0, 1'b0, 24'ha5c3e1);
    `CHK(ctrl_word, 24'ha5c3e1)
    `CHK(asp_link_if_i.result_ready_n, 1'b1)
    run_cmd(1'b1, 1'b1, 1'b0, 1'b0, 24'h5a3c1e);
    `CHK({cal_cnt[7:0], cal_got}, {8'h01, 24'h5a3c1e})
    `CHK(ctrl_word, 24'ha5c3e1)
    run_cmd(1'b0, 1'b0, 1'b0, 1'b0, 24'h000000);
    `CHK(rd_word, 24'ha5c3e1)
    // Output read with nothing ready: line stays released, pulled high
    run_cmd(1'b0, 1'b1, 1'b0, 1'b0, 24'h000000);
    `CHK(rd_word, 24'hffffff)
    // Result lands mid calibration read: read intact, ready goes low
    @(posedge clock);
    cal_read_sel <= 1'b1;
    fork
      run_cmd(1'b0, 1'b1, 1'b0, 1'b0, 24'h000000);
      begin
        repeat (200) @(posedge clock);
        push(24'h123456);
      end
    join
    `CHK(rd_word, 24'h13579b)
    `CHK(asp_link_if_i.result_ready_n, 1'b0)
    @(posedge clock);
    cal_read_sel <= 1'b0;
    push(24'habcdef);
    run_cmd(1'b0, 1'b1, 1'b0, 1'b1, 24'h000000);
    `CHK(rd_word, 24'habcdef)
    `CHK(asp_link_if_i.result_ready_n, 1'b1)
    // Result arriving during an output read is dropped
    push(24'h246802);
    fork
      run_cmd(1'b0, 1'b1, 1'b0, 1'b1, 24'h000000);
      begin
        repeat (200) @(posedge clock);
        push(24'h777777);
      end
    join
    `CHK(rd_word, 24'h246802)
    `CHK({lost_cnt[7:0], asp_link_if_i.result_ready_n}, {8'h01, 1'b1})
    run_cmd(1'b0, 1'b1, 1'b0, 1'b0, 24'h000000);
    `CHK(rd_word, 24'hffffff)
    // Short output word
    @(posedge clock);
    out_word_short <= 1'b1;
    push(24'h987600);
    run_cmd(1'b0, 1'b1, 1'b1, 1'b1, 24'h000000);
    `CHK(rd_word, 24'h009876)
    `CHK(asp_link_if_i.result_ready_n, 1'b1)
    @(posedge clock);
    out_word_short <= 1'b0;
    // Write, paused half way, while a result waits leaves ready low
    push(24'h111111);
    run_cmd(1'b1, 1'b0, 1'b0, 1'b1, 24'h0c0c0c);
    `CHK(asp_link_if_i.result_ready_n, 1'b0)
    `CHK(ctrl_word, 24'h0c0c0c)
    run_cmd(1'b0, 1'b1, 1'b0, 1'b1, 24'h000000);
    `CHK(rd_word, 24'h111111)
    // Self-clocking writes
    @(posedge clock);
    asp_link_if_i.mode <= 1'b1;
    repeat (20) @(posedge clock);
    run_cmd(1'b1, 1'b0, 1'b0, 1'b0, 24'h0f1e2d);
    `CHK(ctrl_word, 24'h0f1e2d)
    run_cmd(1'b1, 1'b1, 1'b0, 1'b0, 24'he1d2c3);
    `CHK({cal_cnt[7:0], cal_got}, {8'h02, 24'he1d2c3})
    `CHK(ctrl_word, 24'h0f1e2d)
    finish_test();
  end
endmodule

// *** dv/asp_link_properties.sv ***
/*
 Checker for the link between converter end and host end.
 Assumes it sees the resolved pins of one asp_link_if, clocked by clock.
*/
`timescale 1ns/1ps
module asp_link_properties (
  input logic clock,
  input logic srst,
  input logic mode,
  input logic sclk,
  input logic sclk_dev_o,
  input logic sclk_dev_oe_n,
  input logic serial_data_io_dev_oe_n,
  input logic read_frame_sync_n,
  input logic write_frame_sync_n,
  input logic register_select,
  input logic result_ready_n
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (srst);

  // Rises of the converter's own clock within one driven stretch
  logic [4:0] rises_r;
  logic [4:0] rises_nxt;
  logic       last_r;
  logic       last_nxt;

  always_comb begin
    last_nxt  = sclk_dev_o;
    rises_nxt = rises_r;
    if (sclk_dev_oe_n) begin
      rises_nxt = 5'h00;
    end else if (sclk_dev_o && !last_r) begin
      rises_nxt = rises_r + 5'h01;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      rises_r <= 5'h00;
      last_r  <= 1'b0;
    end else begin
      rises_r <= rises_nxt;
      last_r  <= last_nxt;
    end
  end

  AST_SELF_CLK_START: assert property (mode && $fell(write_frame_sync_n) |-> ##[1:8] !sclk_dev_oe_n)
    else $error("own clock not started after write sync fall");
  AST_SELF_CLK_COUNT: assert property ($rose(sclk_dev_oe_n) |-> rises_r == asp_pkg::WORD_BITS)
    else $error("own clock rise count differs from word length");
  AST_SELF_CLK_STOP: assert property (rises_r == asp_pkg::WORD_BITS
    && $fell(sclk_dev_o) |-> ##[0:2] sclk_dev_oe_n)
    else $error("own clock still driven after fall past last bit");
  AST_EXT_NO_DEV_CLK: assert property (!mode [*4] |-> sclk_dev_oe_n)
    else $error("converter drives clock in external mode");
  AST_EXT_IDLE_LOW: assert property (!mode && read_frame_sync_n && write_frame_sync_n |-> !sclk)
    else $error("clock high outside a frame");
  AST_DATA_ONLY_READ: assert property (read_frame_sync_n [*6] |-> serial_data_io_dev_oe_n)
    else $error("data driven outside a read frame");
  AST_DATA_OFF_ON_PAUSE: assert property ($rose(read_frame_sync_n) |-> ##[0:5] serial_data_io_dev_oe_n)
    else $error("data not released after read sync rise");
  AST_READY_RISE_RELEASE: assert property ($rose(result_ready_n) |-> ##[0:1] serial_data_io_dev_oe_n)
    else $error("data still driven after ready rise");
  AST_READY_RISE_OUT_READ: assert property ($rose(result_ready_n)
    |-> register_select && !read_frame_sync_n)
    else $error("ready rose outside an output read");
  AST_WRITE_KEEPS_READY: assert property (!write_frame_sync_n |-> !$rose(result_ready_n))
    else $error("ready rose during a write");
  AST_SELECT_STABLE: assert property ((!read_frame_sync_n || !write_frame_sync_n) &&
    (!$past(read_frame_sync_n) || !$past(write_frame_sync_n)) |-> $stable(register_select))
    else $error("select moved inside a frame");

  cover property ($rose(result_ready_n));
  cover property ($fell(sclk_dev_oe_n));
  cover property ($fell(read_frame_sync_n) && !register_select);
  cover property ($rose(read_frame_sync_n) && !result_ready_n);
endmodule

// *** hdl/asp_dev_end.sv ***
/*
 Converter end of the framed serial port: control register, calibration
 write strobe, output register with its ready flag, both clocking modes
 for writes, external-clock reads.
 Assumes all link pins are asynchronous and sampled by clock.
*/
`timescale 1ns/1ps
// Overview of operation
// - Writes ignore and never change ready flag
// - Host writes exactly 24 bits
// - Select low control, high calibration on writes
// - Write sync fall starts own clock
// - Self-clock write samples on rising, MSB first
// - Own clock stops after fall past LSB
// - Mode low: clock pin is host input
// - Select picks control or output/calibration read
// - Ready low on result, high after last bit
// - Unread register keeps updating, ready stays low
// - Result during output read is dropped
// - Output read refused while ready high
// - Control/calibration reads ignore ready, 24 bits
// - Host holds clock low between transfers
// - Read sync puts MSB; shift on falls
// - Last fall raises ready, releases data
// - Read pauses release data, keep position
// - External write captures during high, MSB first
// - Write pauses resume at next bit
// - Data driven only in active read frame
module asp_dev_end (
  input  wire logic        clock,
  input  wire logic        srst,
  input  wire logic        clk_en,
  asp_link_if.dev          link,
  input  wire logic        result_valid,
  input  wire logic [23:0] result_word,
  input  wire logic        out_word_short,
  input  wire logic        cal_read_sel,
  input  wire logic [23:0] cal_rd_word,
  output logic [23:0]      ctrl_word,
  output logic             cal_wr_valid,
  output logic [23:0]      cal_wr_word,
  output logic             result_lost
);
  logic [5:0]  pin_raw, s1_r, s2_r;
  logic [2:0]  d_r;
  logic        mode_s, sclk_s, din_s, rfs_s, tfs_s, a0_s;
  logic        ex_rise, ex_fall, rfs_fall, tfs_fall, se_rise, se_fall, bit_rise;
  logic        sc_run_r, sc_run_nxt, sc_lvl_r, sc_lvl_nxt, sc_last_r, sc_last_nxt;
  logic [7:0]  sc_div_r, sc_div_nxt;
  logic [23:0] wr_sh_r, wr_sh_nxt, ctrl_r, ctrl_nxt, cal_r, cal_nxt;
  logic [4:0]  wr_cnt_r, wr_cnt_nxt, rd_cnt_r, rd_cnt_nxt, rd_len_r, rd_len_nxt;
  logic        wr_sel_r, wr_sel_nxt, cal_v_r, cal_v_nxt;
  logic [23:0] rd_sh_r, rd_sh_nxt, out_r, out_nxt;
  logic        rd_act_r, rd_act_nxt, rd_out_r, rd_out_nxt;
  logic        result_ready_n_r, result_ready_n_nxt, lost_r, lost_nxt, sdo_r, sdo_nxt, sdo_oe_n_r, sdo_oe_n_nxt;

  assign pin_raw = {link.mode, link.sclk, link.serial_data_io,
                    link.read_frame_sync_n, link.write_frame_sync_n, link.register_select};
  assign mode_s   = s2_r[5];
  assign sclk_s   = s2_r[4];
  assign din_s    = s2_r[3];
  assign rfs_s    = s2_r[2];
  assign tfs_s    = s2_r[1];
  assign a0_s     = s2_r[0];
  // Pin clock only counts while in external mode
  assign ex_rise  = ~mode_s & sclk_s & ~d_r[2];
  assign ex_fall  = ~mode_s & ~sclk_s & d_r[2];
  assign rfs_fall = ~rfs_s & d_r[1];
  assign tfs_fall = ~tfs_s & d_r[0];

  always_ff @(posedge clock) begin
    if (srst) begin
      s1_r <= asp_pkg::DEV_SYNC_RST;
      s2_r <= asp_pkg::DEV_SYNC_RST;
      d_r  <= 3'h3;
    end else if (clk_en) begin
      s1_r <= pin_raw;
      s2_r <= s1_r;
      d_r  <= {s2_r[4], s2_r[2], s2_r[1]};
    end
  end

  always_comb begin
    sc_run_nxt = sc_run_r;  sc_lvl_nxt = sc_lvl_r;  sc_last_nxt = sc_last_r;
    sc_div_nxt = sc_div_r;  se_rise = 1'b0;  se_fall = 1'b0;
    wr_sh_nxt = wr_sh_r;  wr_cnt_nxt = wr_cnt_r;  wr_sel_nxt = wr_sel_r;
    ctrl_nxt = ctrl_r;  cal_nxt = cal_r;  cal_v_nxt = 1'b0;
    rd_sh_nxt = rd_sh_r;  rd_cnt_nxt = rd_cnt_r;  rd_len_nxt = rd_len_r;
    rd_act_nxt = rd_act_r;  rd_out_nxt = rd_out_r;  out_nxt = out_r;
    result_ready_n_nxt = result_ready_n_r;  lost_nxt = 1'b0;

    // Own clock: divider toggles while running, idle phase low
    if (sc_run_r) begin
      if (sc_div_r == 8'h00) begin
        sc_div_nxt = asp_pkg::SELF_HALF_CYC;
        sc_lvl_nxt = ~sc_lvl_r;
        se_rise    = ~sc_lvl_r;
        se_fall    = sc_lvl_r;
      end else begin
        sc_div_nxt = sc_div_r - 8'h01;
      end
    end else if (mode_s && tfs_fall) begin
      sc_run_nxt = 1'b1;
      sc_lvl_nxt = 1'b0;
      sc_div_nxt = asp_pkg::SELF_HALF_CYC;
    end
    if (se_fall && sc_last_r) begin
      sc_run_nxt  = 1'b0;
      sc_last_nxt = 1'b0;
    end

    // Write path; ready flag is deliberately untouched here
    bit_rise = mode_s ? se_rise : ex_rise;
    if (!tfs_s && bit_rise) begin
      wr_sh_nxt = {wr_sh_r[22:0], din_s};
      if (wr_cnt_r == 5'h00) wr_sel_nxt = a0_s;
      if (wr_cnt_r == asp_pkg::WORD_BITS - 5'h01) begin
        wr_cnt_nxt  = 5'h00;
        sc_last_nxt = mode_s;
        if (wr_sel_r) begin
          cal_nxt   = {wr_sh_r[22:0], din_s};
          cal_v_nxt = 1'b1;
        end else begin
          ctrl_nxt  = {wr_sh_r[22:0], din_s};
        end
      end else begin
        wr_cnt_nxt = wr_cnt_r + 5'h01;
      end
    end

    // Read start: only a sync fall with no word pending loads a source
    if (rfs_fall && !rd_act_r && !mode_s) begin
      rd_cnt_nxt = 5'h00;
      rd_len_nxt = asp_pkg::WORD_BITS;
      rd_out_nxt = 1'b0;
      if (!a0_s) begin
        rd_sh_nxt  = ctrl_r;
        rd_act_nxt = 1'b1;
      end else if (cal_read_sel) begin
        rd_sh_nxt  = cal_rd_word;
        rd_act_nxt = 1'b1;
      end else if (!result_ready_n_r) begin
        rd_sh_nxt  = out_r;
        rd_out_nxt = 1'b1;
        rd_act_nxt = 1'b1;
        if (out_word_short) rd_len_nxt = asp_pkg::SHORT_BITS;
      end
    end else if (rd_act_r && !rfs_s && ex_fall) begin
      rd_sh_nxt = {rd_sh_r[22:0], 1'b0};
      if (rd_cnt_r + 5'h01 == rd_len_r) begin
        rd_act_nxt = 1'b0;
        rd_cnt_nxt = 5'h00;
        if (rd_out_r) result_ready_n_nxt = 1'b1;
      end else begin
        rd_cnt_nxt = rd_cnt_r + 5'h01;
      end
    end

    // New conversion result
    if (result_valid) begin
      if (rd_act_r && rd_out_r) begin
        lost_nxt = 1'b1;
      end else begin
        out_nxt  = result_word;
        result_ready_n_nxt = 1'b0;
      end
    end

    // Data pin released outside an active, unpaused read frame
    sdo_nxt      = rd_sh_nxt[23];
    sdo_oe_n_nxt = ~(rd_act_nxt & ~rfs_s & ~mode_s);
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      sc_run_r <= 1'b0;  sc_lvl_r <= 1'b0;  sc_last_r <= 1'b0;  sc_div_r <= 8'h00;
      wr_sh_r <= 24'h000000;  wr_cnt_r <= 5'h00;  wr_sel_r <= 1'b0;
      ctrl_r <= asp_pkg::CTRL_RESET;  cal_r <= 24'h000000;  cal_v_r <= 1'b0;
      rd_sh_r <= 24'h000000;  rd_cnt_r <= 5'h00;  rd_len_r <= asp_pkg::WORD_BITS;
      rd_act_r <= 1'b0;  rd_out_r <= 1'b0;  out_r <= 24'h000000;
      result_ready_n_r <= 1'b1;  lost_r <= 1'b0;  sdo_r <= 1'b1;  sdo_oe_n_r <= 1'b1;
    end else if (clk_en) begin
      sc_run_r <= sc_run_nxt;  sc_lvl_r <= sc_lvl_nxt;  sc_last_r <= sc_last_nxt;
      sc_div_r <= sc_div_nxt;
      wr_sh_r <= wr_sh_nxt;  wr_cnt_r <= wr_cnt_nxt;  wr_sel_r <= wr_sel_nxt;
      ctrl_r <= ctrl_nxt;  cal_r <= cal_nxt;  cal_v_r <= cal_v_nxt;
      rd_sh_r <= rd_sh_nxt;  rd_cnt_r <= rd_cnt_nxt;  rd_len_r <= rd_len_nxt;
      rd_act_r <= rd_act_nxt;  rd_out_r <= rd_out_nxt;  out_r <= out_nxt;
      result_ready_n_r <= result_ready_n_nxt;  lost_r <= lost_nxt;  sdo_r <= sdo_nxt;  sdo_oe_n_r <= sdo_oe_n_nxt;
    end
  end

  assign link.sclk_dev_o     = sc_lvl_r;
  assign link.sclk_dev_oe_n  = ~sc_run_r;
  assign link.serial_data_io_dev_o    = sdo_r;
  assign link.serial_data_io_dev_oe_n = sdo_oe_n_r;
  assign link.result_ready_n = result_ready_n_r;
  assign ctrl_word           = ctrl_r;
  assign cal_wr_valid        = cal_v_r;
  assign cal_wr_word         = cal_r;
  assign result_lost         = lost_r;
endmodule

// *** hdl/asp_host_end.sv ***
/*
 Host end: runs one 24-bit write, or in external-clock mode one 16/24-bit read, per command.
 Assumes the link pins come from another domain and are synchronised here.
*/
`timescale 1ns/1ps
module asp_host_end (
  input  wire logic        clock,
  input  wire logic        srst,
  input  wire logic        clk_en,
  asp_link_if.host         link,
  input  wire logic        cmd_valid,
  output logic             cmd_ready,
  input  wire logic        cmd_write,
  input  wire logic        cmd_select,
  input  wire logic        cmd_short,
  input  wire logic        cmd_wait_ready,
  input  wire logic [23:0] cmd_word,
  output logic             rsp_valid,
  output logic [23:0]      rsp_word
);
  asp_pkg::asp_host_state_type st_r, st_nxt;
  logic [3:0]  s1_r, s2_r;
  logic        sclk_d_r;
  logic [7:0]  div_r, div_nxt;
  logic [4:0]  cnt_r, cnt_nxt, len_r, len_nxt;
  logic [23:0] sh_r, sh_nxt, rsp_r, rsp_nxt;
  logic        wr_r, wr_nxt, sclk_r, sclk_nxt, sclk_oe_n_r, sclk_oe_n_nxt;
  logic        sdo_r, sdo_nxt, sdo_oe_n_r, sdo_oe_n_nxt, rfs_r, rfs_nxt, tfs_r, tfs_nxt;
  logic        sel_r, sel_nxt, rdy_r, rdy_nxt, rv_r, rv_nxt;
  logic        pz_r, pz_nxt, rs_r, rs_nxt;
  logic        mode_s, sclk_s, din_s, result_ready_n_s, s_rise, s_fall, tick;

  assign mode_s = s2_r[3];
  assign sclk_s = s2_r[2];
  assign din_s  = s2_r[1];
  assign result_ready_n_s = s2_r[0];
  assign s_rise = sclk_s & ~sclk_d_r;
  assign s_fall = ~sclk_s & sclk_d_r;
  assign tick   = (div_r == 8'h00);

  always_ff @(posedge clock) begin
    if (srst) begin
      s1_r     <= asp_pkg::HOST_SYNC_RST;
      s2_r     <= asp_pkg::HOST_SYNC_RST;
      sclk_d_r <= 1'b0;
    end else if (clk_en) begin
      s1_r     <= {link.mode, link.sclk, link.serial_data_io, link.result_ready_n};
      s2_r     <= s1_r;
      sclk_d_r <= s2_r[2];
    end
  end

  always_comb begin
    st_nxt = st_r;  div_nxt = tick ? 8'h00 : div_r - 8'h01;
    cnt_nxt = cnt_r;  len_nxt = len_r;  sh_nxt = sh_r;  rsp_nxt = rsp_r;
    wr_nxt = wr_r;  sclk_nxt = sclk_r;  sdo_nxt = sdo_r;  sdo_oe_n_nxt = sdo_oe_n_r;
    rfs_nxt = rfs_r;  tfs_nxt = tfs_r;  sel_nxt = sel_r;  rdy_nxt = rdy_r;  rv_nxt = 1'b0;
    pz_nxt = pz_r;  rs_nxt = rs_r;
    // Clock driven by us in external mode, left to the converter otherwise
    sclk_oe_n_nxt = mode_s;
    unique case (st_r)
      asp_pkg::ASP_IDLE: begin
        rdy_nxt = 1'b1;
        if (cmd_valid && rdy_r) begin
          rdy_nxt = 1'b0;
          sel_nxt = cmd_select;
          wr_nxt  = cmd_write;
          sh_nxt  = cmd_word;
          cnt_nxt = 5'h00;
          // Waiting reads and flagged external-clock writes pause once, after bit 12
          pz_nxt  = cmd_wait_ready;
          div_nxt = asp_pkg::HOST_HALF_CYC;
          len_nxt = (!cmd_write && cmd_short) ? asp_pkg::SHORT_BITS : asp_pkg::WORD_BITS;
          if (cmd_write) begin
            tfs_nxt      = 1'b0;
            sdo_oe_n_nxt = 1'b0;
            sdo_nxt      = cmd_word[23];
            st_nxt       = mode_s ? asp_pkg::ASP_SELF : asp_pkg::ASP_LOW;
          end else if (mode_s) begin
            rsp_nxt = 24'h000000;
            rv_nxt  = 1'b1;
            st_nxt  = asp_pkg::ASP_GAP;
          end else if (cmd_wait_ready) begin
            st_nxt = asp_pkg::ASP_WAIT;
          end else begin
            rfs_nxt = 1'b0;
            st_nxt  = asp_pkg::ASP_LOW;
          end
        end
      end
      asp_pkg::ASP_WAIT: begin
        // Output register answers only while ready is low
        div_nxt = asp_pkg::HOST_HALF_CYC;
        if (!result_ready_n_s) begin
          rfs_nxt = 1'b0;
          st_nxt  = asp_pkg::ASP_LOW;
        end
      end
      asp_pkg::ASP_LOW: if (tick) begin
        div_nxt = asp_pkg::HOST_HALF_CYC;
        if (pz_r && cnt_r == 5'h0c) begin
          // Sync lifted well inside clock low, so the last fall is already taken
          pz_nxt  = 1'b0;
          rs_nxt  = 1'b1;
          rfs_nxt = 1'b1;
          tfs_nxt = 1'b1;
          st_nxt  = asp_pkg::ASP_GAP;
        end else begin
          sclk_nxt = 1'b1;
          st_nxt   = asp_pkg::ASP_HIGH;
          if (!wr_r) sh_nxt = {sh_r[22:0], din_s};
        end
      end
      asp_pkg::ASP_HIGH: if (tick) begin
        sclk_nxt = 1'b0;
        div_nxt  = asp_pkg::HOST_HALF_CYC;
        cnt_nxt  = cnt_r + 5'h01;
        if (cnt_r + 5'h01 == len_r) begin
          st_nxt = asp_pkg::ASP_TAIL;
        end else begin
          st_nxt = asp_pkg::ASP_LOW;
          if (wr_r) begin
            sh_nxt  = {sh_r[22:0], 1'b0};
            sdo_nxt = sh_r[22];
          end
        end
      end
      asp_pkg::ASP_TAIL: if (tick) begin
        rfs_nxt      = 1'b1;
        tfs_nxt      = 1'b1;
        sdo_oe_n_nxt = 1'b1;
        rv_nxt       = ~wr_r;
        rsp_nxt      = sh_r;
        div_nxt      = asp_pkg::HOST_HALF_CYC;
        st_nxt       = asp_pkg::ASP_GAP;
      end
      asp_pkg::ASP_SELF: begin
        if (s_rise) cnt_nxt = cnt_r + 5'h01;
        if (s_fall) begin
          if (cnt_r == asp_pkg::WORD_BITS) begin
            tfs_nxt      = 1'b1;
            sdo_oe_n_nxt = 1'b1;
            div_nxt      = asp_pkg::HOST_HALF_CYC;
            st_nxt       = asp_pkg::ASP_GAP;
          end else begin
            sh_nxt  = {sh_r[22:0], 1'b0};
            sdo_nxt = sh_r[22];
          end
        end
      end
      asp_pkg::ASP_GAP: if (tick) begin
        if (rs_r) begin
          rs_nxt  = 1'b0;
          rfs_nxt = wr_r;
          tfs_nxt = ~wr_r;
          div_nxt = asp_pkg::HOST_HALF_CYC;
          st_nxt  = asp_pkg::ASP_LOW;
        end else begin
          st_nxt = asp_pkg::ASP_IDLE;
        end
      end
      default: st_nxt = asp_pkg::ASP_IDLE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      st_r <= asp_pkg::ASP_IDLE;  div_r <= 8'h00;  cnt_r <= 5'h00;
      len_r <= asp_pkg::WORD_BITS;  sh_r <= 24'h000000;  rsp_r <= 24'h000000;
      wr_r <= 1'b0;  sclk_r <= 1'b0;  sclk_oe_n_r <= 1'b1;  sdo_r <= 1'b1;
      sdo_oe_n_r <= 1'b1;  rfs_r <= 1'b1;  tfs_r <= 1'b1;  sel_r <= 1'b0;
      rdy_r <= 1'b0;  rv_r <= 1'b0;
      pz_r <= 1'b0;  rs_r <= 1'b0;
    end else if (clk_en) begin
      st_r <= st_nxt;  div_r <= div_nxt;  cnt_r <= cnt_nxt;
      len_r <= len_nxt;  sh_r <= sh_nxt;  rsp_r <= rsp_nxt;
      wr_r <= wr_nxt;  sclk_r <= sclk_nxt;  sclk_oe_n_r <= sclk_oe_n_nxt;  sdo_r <= sdo_nxt;
      sdo_oe_n_r <= sdo_oe_n_nxt;  rfs_r <= rfs_nxt;  tfs_r <= tfs_nxt;  sel_r <= sel_nxt;
      rdy_r <= rdy_nxt;  rv_r <= rv_nxt;
      pz_r <= pz_nxt;  rs_r <= rs_nxt;
    end
  end

  assign link.sclk_host_o        = sclk_r;
  assign link.sclk_host_oe_n     = sclk_oe_n_r;
  assign link.serial_data_io_host_o       = sdo_r;
  assign link.serial_data_io_host_oe_n    = sdo_oe_n_r;
  assign link.read_frame_sync_n  = rfs_r;
  assign link.write_frame_sync_n = tfs_r;
  assign link.register_select    = sel_r;
  assign cmd_ready               = rdy_r;
  assign rsp_valid               = rv_r;
  assign rsp_word                = rsp_r;
endmodule

// *** hdl/asp_link_if.sv ***
/*
 Pins between converter end and host end, with wire resolution.
 Assumes the bench drives mode; clock line is pulled low, data line high.
*/
`timescale 1ns/1ps
interface asp_link_if;
  logic mode;
  logic sclk;
  logic sclk_dev_o;
  logic sclk_dev_oe_n;
  logic sclk_host_o;
  logic sclk_host_oe_n;
  logic serial_data_io;
  logic serial_data_io_dev_o;
  logic serial_data_io_dev_oe_n;
  logic serial_data_io_host_o;
  logic serial_data_io_host_oe_n;
  logic read_frame_sync_n;
  logic write_frame_sync_n;
  logic register_select;
  logic result_ready_n;

  assign sclk = !sclk_dev_oe_n ? sclk_dev_o : (!sclk_host_oe_n ? sclk_host_o : 1'b0);
  assign serial_data_io = !serial_data_io_dev_oe_n ? serial_data_io_dev_o :
                          (!serial_data_io_host_oe_n ? serial_data_io_host_o : 1'b1);

  modport dev (
    input  mode, sclk, serial_data_io, read_frame_sync_n, write_frame_sync_n,
    input  register_select,
    output sclk_dev_o, sclk_dev_oe_n, serial_data_io_dev_o, serial_data_io_dev_oe_n, result_ready_n
  );
  modport host (
    input  mode, sclk, serial_data_io, result_ready_n,
    output sclk_host_o, sclk_host_oe_n, serial_data_io_host_o, serial_data_io_host_oe_n,
    output read_frame_sync_n, write_frame_sync_n, register_select
  );
endinterface

// *** hdl/asp_pkg.sv ***
/*
 Shared constants for both ends of the framed converter serial port.
 Assumes a 200 MHz system clock on both ends.
*/
package asp_pkg;
  localparam int             CLK_PERIOD_PS = 5000;
  localparam logic [4:0]     WORD_BITS     = 5'h18;
  localparam logic [4:0]     SHORT_BITS    = 5'h10;
  localparam logic [23:0]    CTRL_RESET    = 24'h000000;
  // Half period of the clock the converter makes in self-clocking mode
  localparam int             SELF_HALF_NS  = 100;
  localparam logic [7:0]     SELF_HALF_CYC = 8'((SELF_HALF_NS * 1000) / CLK_PERIOD_PS - 1);
  // Half period of the clock the host makes in external mode
  localparam int             HOST_HALF_NS  = 50;
  localparam logic [7:0]     HOST_HALF_CYC = 8'((HOST_HALF_NS * 1000) / CLK_PERIOD_PS - 1);
  // Idle levels of synchronised pins: mode, clock, data, read sync, write sync, select
  localparam logic [5:0]     DEV_SYNC_RST  = 6'h0e;
  // Idle levels on the host side: mode, clock, data, ready
  localparam logic [3:0]     HOST_SYNC_RST = 4'h3;
  typedef enum logic [2:0] {
    ASP_IDLE, ASP_WAIT, ASP_LOW, ASP_HIGH, ASP_TAIL, ASP_SELF, ASP_GAP
  } asp_host_state_type;
endpackage
